/* File: src/nfcreg_pkg.sv */
// nfcreg_pkg: register map, field masks, timing constants and carriers of the timer/mask bank
package nfcreg_pkg;

	// ==========================================================
	// register spaces and offsets
	localparam logic SPACE_A = 1'b0;
	localparam logic SPACE_B = 1'b1;
	localparam logic [5:0] OFF_PEER_WAIT = 6'h15; // space A
	localparam logic [5:0] OFF_MASK_MAIN = 6'h16; // space A
	localparam logic [5:0] OFF_MASK_TMR = 6'h17; // space A
	localparam logic [5:0] OFF_MASK_ERR = 6'h18; // space A
	localparam logic [5:0] OFF_MASK_TGT = 6'h19; // space A
	localparam logic [5:0] OFF_STAT_MAIN = 6'h1A; // space A, read clears
	localparam logic [5:0] OFF_STAT_TMR = 6'h1B;
	localparam logic [5:0] OFF_STAT_ERR = 6'h1C;
	localparam logic [5:0] OFF_STAT_TGT = 6'h1D;
	localparam logic [5:0] OFF_SQUELCH = 6'h0F; // space B
	localparam logic [5:0] OFF_GUARD = 6'h15; // space B
	localparam logic [5:0] OFF_CLR_MAIN = 6'h1A; // space B, write-only clear
	localparam logic [5:0] OFF_CLR_TMR = 6'h1B;
	localparam logic [5:0] OFF_CLR_ERR = 6'h1C;
	localparam logic [5:0] OFF_CLR_TGT = 6'h1D;

	// ==========================================================
	// reset values and implemented bits (unused bits read zero)
	localparam logic [7:0] RST_SQUELCH = 8'h00;
	localparam logic [7:0] RST_PEER_WAIT = 8'h80;
	localparam logic [7:0] RST_GUARD = 8'h33;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] VALID_MAIN = 8'hFE;
	localparam logic [7:0] VALID_TMR = 8'hFF;
	localparam logic [7:0] VALID_ERR = 8'hFE;
	localparam logic [7:0] VALID_TGT = 8'hFB;
	localparam int BIT_TGT_PEER_WAIT = 7;
	localparam int BIT_TMR_GUARD = 1;
	localparam logic [7:0] SQT_SHORT_MAX = 8'h05;

	// ==========================================================
	// timing: carrier steps and clock-derived delays
	localparam int FC_STEP_PEER = 64;
	localparam int FC_STEP_MRT_FINE = 64;
	localparam int FC_STEP_MRT_COARSE = 512;
	localparam int FC_STEP_GUARD = 2048;
	localparam logic [10:0] PRE_LAST_PEER = 11'(FC_STEP_PEER - 1);
	localparam logic [10:0] PRE_LAST_FINE = 11'(FC_STEP_MRT_FINE - 1);
	localparam logic [10:0] PRE_LAST_COARSE = 11'(FC_STEP_MRT_COARSE - 1);
	localparam logic [10:0] PRE_LAST_GUARD = 11'(FC_STEP_GUARD - 1);
	localparam int CLK_KHZ = 20000;
	localparam int SQ_DELAY_US = 20;
	localparam int GUARD_BASE_US = 75;
	localparam int SQ_DELAY_CYC = (SQ_DELAY_US * CLK_KHZ + 999) / 1000;
	localparam int GUARD_BASE_CYC = (GUARD_BASE_US * CLK_KHZ + 999) / 1000;
	localparam logic [10:0] SQ_DLY_LAST = 11'(SQ_DELAY_CYC - 1);
	localparam logic [10:0] GUARD_BASE_LAST = 11'(GUARD_BASE_CYC - 1);

	// ==========================================================
	// carriers
	typedef struct packed {
		logic wr;
		logic rd;
		logic space;
		logic [5:0] addr;
		logic [7:0] wdata;
	} nfcreg_req_t;

	typedef struct packed {
		logic [7:0] main;
		logic [7:0] tmr;
		logic [7:0] err;
		logic [7:0] tgt;
	} nfcreg_irq_t;

	// ==========================================================
	// helpers
	function automatic logic hit(input nfcreg_req_t r, input logic sp, input logic [5:0] off);
		return (r.space == sp) && (r.addr == off);
	endfunction : hit

	// advance a {steps, prescaler} pair by one carrier tick
	function automatic logic [18:0] step_adv(input logic [10:0] pre, input logic [7:0] steps,
		input logic [10:0] last, input logic tick);
		logic [18:0] r;
		r = {steps, pre};
		if (tick)
		begin
			if (pre == last)
				r = {8'(steps + 8'h01), 11'h000};
			else
				r = {steps, 11'(pre + 11'h001)};
		end
		return r;
	endfunction : step_adv

endpackage : nfcreg_pkg

/* File: src/nfcreg_top.sv */
// nfcreg_top: timer configuration, interrupt masks, status and the timers they steer
module nfcreg_top
(
	input wire logic clk_in, // 20 MHz clock
	input wire logic rst_in, // synchronous reset, high
	input wire logic ce_in, // clock enable, freezes all state
	input wire nfcreg_pkg::nfcreg_req_t req_in, // register access
	output logic [7:0] rdata_out, // read data, cycle after read
	output logic irq_out, // interrupt request level
	input wire nfcreg_pkg::nfcreg_irq_t events_in, // source event pulses
	input wire logic fc_tick_in, // one pulse per carrier period
	input wire logic active_peer_mode_in, // active peer mode selected
	input wire logic peer_wait_start_in, // start waiting for peer field
	input wire logic peer_field_on_in, // peer field detected
	output logic peer_wait_expired_out, // peer wait ran out
	input wire logic tx_end_in, // end of reader transmission
	input wire logic [7:0] mrt_in, // mask receive timer value
	input wire logic mrt_step_in, // mask receive step select
	output logic squelch_on_out, // squelch active
	output logic gain_lock_out, // squelch gain frozen for gain control
	input wire logic field_on_cmd_in, // field-on command started
	output logic guard_active_out, // guard interval running
	output logic guard_done_out // guard interval ended
);
	import nfcreg_pkg::*;

	typedef enum logic {PW_IDLE, PW_RUN} nfcreg_pw_t;
	typedef enum logic [1:0] {SQ_IDLE, SQ_DELAY, SQ_ON, SQ_LOCK} nfcreg_sq_t;
	typedef enum logic [1:0] {G_IDLE, G_BASE, G_STEP} nfcreg_gd_t;

	logic [7:0] peer_wait_q;
	logic [7:0] sqt_q;
	logic [7:0] guard_time_q;
	nfcreg_irq_t mask_q;
	nfcreg_irq_t stat_q;
	nfcreg_irq_t stat_d;
	nfcreg_irq_t ev_set;
	nfcreg_irq_t clr;
	logic [7:0] rdata_q;
	logic [7:0] rd_mux;

	// ==========================================================
	// register decode, two spaces share the address range
	wire wr_peer = req_in.wr && hit(req_in, SPACE_A, OFF_PEER_WAIT);
	wire wr_sqt = req_in.wr && hit(req_in, SPACE_B, OFF_SQUELCH);
	wire wr_guard = req_in.wr && hit(req_in, SPACE_B, OFF_GUARD);
	wire wr_mmain = req_in.wr && hit(req_in, SPACE_A, OFF_MASK_MAIN);
	wire wr_mtmr = req_in.wr && hit(req_in, SPACE_A, OFF_MASK_TMR);
	wire wr_merr = req_in.wr && hit(req_in, SPACE_A, OFF_MASK_ERR);
	wire wr_mtgt = req_in.wr && hit(req_in, SPACE_A, OFF_MASK_TGT);

	// status clears: a status read empties that register, a space B clear write clears the bits written
	wire rd_smain = req_in.rd && hit(req_in, SPACE_A, OFF_STAT_MAIN);
	wire rd_stmr = req_in.rd && hit(req_in, SPACE_A, OFF_STAT_TMR);
	wire rd_serr = req_in.rd && hit(req_in, SPACE_A, OFF_STAT_ERR);
	wire rd_stgt = req_in.rd && hit(req_in, SPACE_A, OFF_STAT_TGT);
	wire wr_cmain = req_in.wr && hit(req_in, SPACE_B, OFF_CLR_MAIN);
	wire wr_ctmr = req_in.wr && hit(req_in, SPACE_B, OFF_CLR_TMR);
	wire wr_cerr = req_in.wr && hit(req_in, SPACE_B, OFF_CLR_ERR);
	wire wr_ctgt = req_in.wr && hit(req_in, SPACE_B, OFF_CLR_TGT);

	// read multiplexer, unmapped addresses read zero
	assign rd_mux = hit(req_in, SPACE_A, OFF_PEER_WAIT) ? peer_wait_q :
		hit(req_in, SPACE_A, OFF_MASK_MAIN) ? mask_q.main :
		hit(req_in, SPACE_A, OFF_MASK_TMR) ? mask_q.tmr :
		hit(req_in, SPACE_A, OFF_MASK_ERR) ? mask_q.err :
		hit(req_in, SPACE_A, OFF_MASK_TGT) ? mask_q.tgt :
		hit(req_in, SPACE_A, OFF_STAT_MAIN) ? stat_q.main :
		hit(req_in, SPACE_A, OFF_STAT_TMR) ? stat_q.tmr :
		hit(req_in, SPACE_A, OFF_STAT_ERR) ? stat_q.err :
		hit(req_in, SPACE_A, OFF_STAT_TGT) ? stat_q.tgt :
		hit(req_in, SPACE_B, OFF_SQUELCH) ? sqt_q :
		hit(req_in, SPACE_B, OFF_GUARD) ? guard_time_q : 8'h00;

	// configuration and mask registers
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			peer_wait_q <= RST_PEER_WAIT;
			sqt_q <= RST_SQUELCH;
			guard_time_q <= RST_GUARD;
			mask_q <= {RST_MASK, RST_MASK, RST_MASK, RST_MASK};
		end
		else if (ce_in)
		begin
			if (wr_peer) peer_wait_q <= req_in.wdata;
			if (wr_sqt) sqt_q <= req_in.wdata;
			if (wr_guard) guard_time_q <= req_in.wdata;
			if (wr_mmain) mask_q.main <= req_in.wdata & VALID_MAIN;
			if (wr_mtmr) mask_q.tmr <= req_in.wdata & VALID_TMR;
			if (wr_merr) mask_q.err <= req_in.wdata & VALID_ERR;
			if (wr_mtgt) mask_q.tgt <= req_in.wdata & VALID_TGT;
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			rdata_q <= 8'h00;
		else if (ce_in)
			rdata_q <= req_in.rd ? rd_mux : 8'h00;
	end
	assign rdata_out = rdata_q;

	// ==========================================================
	// interrupt status: sticky, set wins over clear
	logic pw_exp_q;
	logic guard_done_q;
	assign ev_set.main = events_in.main & VALID_MAIN;
	assign ev_set.tmr = (events_in.tmr | (8'(guard_done_q) << BIT_TMR_GUARD)) & VALID_TMR;
	assign ev_set.err = events_in.err & VALID_ERR;
	assign ev_set.tgt = (events_in.tgt | (8'(pw_exp_q) << BIT_TGT_PEER_WAIT)) & VALID_TGT;
	assign clr.main = (rd_smain ? 8'hFF : 8'h00) | (wr_cmain ? req_in.wdata : 8'h00);
	assign clr.tmr = (rd_stmr ? 8'hFF : 8'h00) | (wr_ctmr ? req_in.wdata : 8'h00);
	assign clr.err = (rd_serr ? 8'hFF : 8'h00) | (wr_cerr ? req_in.wdata : 8'h00);
	assign clr.tgt = (rd_stgt ? 8'hFF : 8'h00) | (wr_ctgt ? req_in.wdata : 8'h00);
	assign stat_d.main = (stat_q.main & ~clr.main) | ev_set.main;
	assign stat_d.tmr = (stat_q.tmr & ~clr.tmr) | ev_set.tmr;
	assign stat_d.err = (stat_q.err & ~clr.err) | ev_set.err;
	assign stat_d.tgt = (stat_q.tgt & ~clr.tgt) | ev_set.tgt;

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			stat_q <= '0;
		else if (ce_in)
			stat_q <= stat_d;
	end

	// a mask bit at one hides its flag from the request line
	wire [7:0] pend_main = stat_q.main & ~mask_q.main;
	wire [7:0] pend_tmr = stat_q.tmr & ~mask_q.tmr;
	wire [7:0] pend_err = stat_q.err & ~mask_q.err;
	wire [7:0] pend_tgt = stat_q.tgt & ~mask_q.tgt;
	assign irq_out = |{pend_main, pend_tmr, pend_err, pend_tgt};

	// ==========================================================
	// peer field wait timer
	nfcreg_pw_t pw_state_q;
	logic [10:0] pw_pre_q;
	logic [7:0] pw_steps_q;
	wire [18:0] pw_adv = step_adv(pw_pre_q, pw_steps_q, PRE_LAST_PEER, fc_tick_in);

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			pw_state_q <= PW_IDLE;
			pw_pre_q <= 11'h000;
			pw_steps_q <= 8'h00;
			pw_exp_q <= 1'b0;
		end
		else if (ce_in)
		begin
			pw_exp_q <= 1'b0;
			case (pw_state_q)
				PW_IDLE:
					if (peer_wait_start_in && active_peer_mode_in)
					begin
						pw_state_q <= PW_RUN;
						pw_pre_q <= 11'h000;
						pw_steps_q <= 8'h00;
					end
				PW_RUN:
					if (peer_field_on_in || !active_peer_mode_in)
						pw_state_q <= PW_IDLE;
					else if (pw_steps_q == peer_wait_q)
					begin
						pw_exp_q <= 1'b1;
						pw_state_q <= PW_IDLE;
					end
					else
						{pw_steps_q, pw_pre_q} <= pw_adv;
				default:
					pw_state_q <= PW_IDLE;
			endcase
		end
	end
	assign peer_wait_expired_out = pw_exp_q;

	// ==========================================================
	// squelch window, counted in mask receive steps from end of transmit
	nfcreg_sq_t sq_state_q;
	logic [10:0] sq_dly_q;
	logic [10:0] sq_pre_q;
	logic [7:0] sq_steps_q;
	wire [10:0] mrt_last = mrt_step_in ? PRE_LAST_COARSE : PRE_LAST_FINE;
	wire [18:0] sq_adv = step_adv(sq_pre_q, sq_steps_q, mrt_last, fc_tick_in);
	wire mrt_hit = (sq_steps_q == mrt_in);
	// a short or over-long value falls back to the mask receive end
	wire sqt_long = (sqt_q > SQT_SHORT_MAX) && (sqt_q < mrt_in);

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			sq_state_q <= SQ_IDLE;
			sq_dly_q <= 11'h000;
			sq_pre_q <= 11'h000;
			sq_steps_q <= 8'h00;
		end
		else if (ce_in)
		begin
			if (tx_end_in)
			begin
				sq_state_q <= SQ_DELAY;
				sq_dly_q <= 11'h000;
				sq_pre_q <= 11'h000;
				sq_steps_q <= 8'h00;
			end
			else
				case (sq_state_q)
					SQ_DELAY:
					begin
						{sq_steps_q, sq_pre_q} <= sq_adv;
						if (mrt_hit)
							sq_state_q <= SQ_IDLE;
						else if (sq_dly_q == SQ_DLY_LAST)
							sq_state_q <= SQ_ON;
						else
							sq_dly_q <= 11'(sq_dly_q + 11'h001);
					end
					SQ_ON:
					begin
						{sq_steps_q, sq_pre_q} <= sq_adv;
						if (sqt_long && (sq_steps_q == sqt_q))
							sq_state_q <= SQ_LOCK;
						else if (mrt_hit)
							sq_state_q <= SQ_IDLE;
					end
					SQ_IDLE, SQ_LOCK:
						sq_state_q <= sq_state_q;
					default:
						sq_state_q <= SQ_IDLE;
				endcase
		end
	end
	// lock holds the reached gain until the next transmit end
	assign squelch_on_out = (sq_state_q == SQ_ON);
	assign gain_lock_out = (sq_state_q == SQ_LOCK);

	// ==========================================================
	// field-on guard: fixed base, then programmed carrier steps
	nfcreg_gd_t g_state_q;
	logic [10:0] g_base_q;
	logic [10:0] g_pre_q;
	logic [7:0] g_steps_q;
	wire [18:0] g_adv = step_adv(g_pre_q, g_steps_q, PRE_LAST_GUARD, fc_tick_in);

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			g_state_q <= G_IDLE;
			g_base_q <= 11'h000;
			g_pre_q <= 11'h000;
			g_steps_q <= 8'h00;
			guard_done_q <= 1'b0;
		end
		else if (ce_in)
		begin
			guard_done_q <= 1'b0;
			if (field_on_cmd_in)
			begin
				g_state_q <= G_BASE;
				g_base_q <= 11'h000;
			end
			else
				case (g_state_q)
					G_BASE:
						if (g_base_q == GUARD_BASE_LAST)
						begin
							g_state_q <= G_STEP;
							g_pre_q <= 11'h000;
							g_steps_q <= 8'h00;
						end
						else
							g_base_q <= 11'(g_base_q + 11'h001);
					G_STEP:
						if (g_steps_q == guard_time_q)
						begin
							guard_done_q <= 1'b1;
							g_state_q <= G_IDLE;
						end
						else
							{g_steps_q, g_pre_q} <= g_adv;
					G_IDLE:
						g_state_q <= G_IDLE;
					default:
						g_state_q <= G_IDLE;
				endcase
		end
	end
	assign guard_active_out = (g_state_q != G_IDLE);
	assign guard_done_out = guard_done_q;

	// ==========================================================
	// assertions
	property p_pw_expire;
		@(posedge clk_in) disable iff (rst_in)
		$rose(peer_wait_expired_out) |-> $past(pw_steps_q) == $past(peer_wait_q);
	endproperty
	a_pw_expire: assert property (p_pw_expire) else $error("peer wait expired early");

	property p_sq_delay;
		@(posedge clk_in) disable iff (rst_in)
		$rose(squelch_on_out) |-> $past(sq_dly_q) == SQ_DLY_LAST;
	endproperty
	a_sq_delay: assert property (p_sq_delay) else $error("squelch start delay wrong");

	property p_gain_lock;
		@(posedge clk_in) disable iff (rst_in)
		$rose(gain_lock_out) |-> ($past(sq_steps_q) == $past(sqt_q)) &&
			($past(sqt_q) > SQT_SHORT_MAX);
	endproperty
	a_gain_lock: assert property (p_gain_lock) else $error("gain lock at wrong step");

	property p_sq_mrt_end;
		@(posedge clk_in) disable iff (rst_in)
		$fell(squelch_on_out) && !gain_lock_out && !$past(tx_end_in)
			|-> $past(sq_steps_q) == $past(mrt_in);
	endproperty
	a_sq_mrt_end: assert property (p_sq_mrt_end) else $error("squelch ended off mrt");

	property p_guard_base;
		@(posedge clk_in) disable iff (rst_in)
		(g_state_q == G_BASE) ##1 (g_state_q == G_STEP) |-> $past(g_base_q) == GUARD_BASE_LAST;
	endproperty
	a_guard_base: assert property (p_guard_base) else $error("guard base length wrong");

	property p_guard_done;
		@(posedge clk_in) disable iff (rst_in)
		$rose(guard_done_out) |-> $past(g_steps_q) == $past(guard_time_q);
	endproperty
	a_guard_done: assert property (p_guard_done) else $error("guard ended at wrong step");

	property p_mask_all;
		@(posedge clk_in) disable iff (rst_in)
		(&(mask_q.main | ~VALID_MAIN)) && (&mask_q.tmr) && (&(mask_q.err | ~VALID_ERR)) &&
			(&(mask_q.tgt | ~VALID_TGT)) |-> !irq_out;
	endproperty
	a_mask_all: assert property (p_mask_all) else $error("masked flag raised irq");

	property p_unmasked;
		@(posedge clk_in) disable iff (rst_in)
		stat_q.tmr[BIT_TMR_GUARD] && !mask_q.tmr[BIT_TMR_GUARD] |-> irq_out;
	endproperty
	a_unmasked: assert property (p_unmasked) else $error("pending flag without irq");

	property p_rd_clear;
		@(posedge clk_in) disable iff (rst_in)
		ce_in && rd_smain && (events_in.main == 8'h00) |=> stat_q.main == 8'h00;
	endproperty
	a_rd_clear: assert property (p_rd_clear) else $error("status not cleared by read");

	property p_set_wins;
		@(posedge clk_in) disable iff (rst_in)
		ce_in && rd_serr && events_in.err[7] |=> stat_q.err[7];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost under read clear");

	property p_space_b;
		@(posedge clk_in) disable iff (rst_in)
		ce_in && req_in.rd && hit(req_in, SPACE_B, OFF_GUARD) |=> rdata_out == $past(guard_time_q);
	endproperty
	a_space_b: assert property (p_space_b) else $error("space B read wrong");

endmodule : nfcreg_top

/* File: testbench/nfcreg_host.sv */
// nfcreg_host: host model issuing register reads and writes on the plain port
module nfcreg_host
(
	input wire logic clk_in, // bench clock
	input wire logic [7:0] rdata_in, // read data from the bank
	output nfcreg_pkg::nfcreg_req_t req_out // request towards the bank
);
	timeunit 1ns;
	timeprecision 1ps;
	import nfcreg_pkg::*;

	// ==========================================================
	// bus cycles
	// idle from time zero so no stray strobe lands during reset
	initial req_out = '0;

	// one-cycle write strobe, released right after the taking edge
	task automatic wr(input logic sp, input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_in);
		req_out <= '{wr: 1'b1, rd: 1'b0, space: sp, addr: a, wdata: d};
		@(posedge clk_in);
		req_out <= '0;
	endtask : wr

	// data stands only in the cycle after the strobe, so sample it there
	task automatic rd(input logic sp, input logic [5:0] a, output logic [7:0] d);
		@(posedge clk_in);
		req_out <= '{wr: 1'b0, rd: 1'b1, space: sp, addr: a, wdata: 8'h00};
		@(posedge clk_in);
		req_out <= '0;
		#1;
		d = rdata_in;
	endtask : rd
endmodule : nfcreg_host

/* File: testbench/nfcreg_top_tb.sv */
// nfcreg_top_tb: self-checking bench for the timer and interrupt mask bank
module nfcreg_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import nfcreg_pkg::*;

	// ==========================================================
	// stimulus and observed signals
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic ce_in = 1'b1;
	logic fc_tick_in = 1'b1; // carrier tick every clock keeps runs short
	logic [2:0] kick = 3'h0; // tx end, field-on command, peer wait start
	logic mode = 1'b0;
	logic field_on = 1'b0;
	logic [7:0] mrt = 8'h00;
	logic step = 1'b0;
	nfcreg_irq_t events = '0;
	nfcreg_req_t req;
	logic [7:0] rdata;
	logic irq, pw_exp, sq_on, g_lock, g_act, g_done;
	logic [7:0] vld [4] = '{VALID_MAIN, VALID_TMR, VALID_ERR, VALID_TGT};
	int fail_count = 0;
	int n_checks = 0;
	wire [3:0] mon = {g_done, pw_exp, ~sq_on, sq_on};

	// free-running 20 MHz clock
	initial forever #25 clk_in = ~clk_in;

	nfcreg_host host (.clk_in(clk_in), .rdata_in(rdata), .req_out(req));

	nfcreg_top DUT (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .req_in(req),
		.rdata_out(rdata), .irq_out(irq), .events_in(events), .fc_tick_in(fc_tick_in),
		.active_peer_mode_in(mode), .peer_wait_start_in(kick[2]),
		.peer_field_on_in(field_on), .peer_wait_expired_out(pw_exp), .tx_end_in(kick[0]),
		.mrt_in(mrt), .mrt_step_in(step), .squelch_on_out(sq_on), .gain_lock_out(g_lock),
		.field_on_cmd_in(kick[1]), .guard_active_out(g_act), .guard_done_out(g_done));

	// ==========================================================
	// shared helpers
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	// cycle counts get a small window: pipeline slack is the designer's
	task automatic rng(input int n, input int lo, input int hi);
		n_checks++;
		if (n < lo || n > hi)
		begin
			fail_count++;
			$display("wrong value at %0t: got %0h expected %0h to %0h", $time, n, lo, hi);
		end
	endtask : rng

	task automatic pulse(input int i);
		@(posedge clk_in);
		kick[i] <= 1'b1;
		@(posedge clk_in);
		kick <= 3'h0;
	endtask : pulse

	// bounded wait; a hang ends the run as a mismatch
	task automatic wait_for(input int sel, input int limit, output int n);
		n = 0;
		do
		begin
			@(posedge clk_in);
			#1;
			n++;
		end
		while (mon[sel] !== 1'b1 && n < limit);
		if (mon[sel] !== 1'b1)
		begin
			chk(8'h00, 8'h01);
			close_out();
		end
	endtask : wait_for

	// ==========================================================
	// scenarios
	task automatic t_space();
		logic [7:0] d;
		host.rd(SPACE_A, OFF_PEER_WAIT, d);
		chk(d, RST_PEER_WAIT);
		host.rd(SPACE_B, OFF_SQUELCH, d);
		chk(d, RST_SQUELCH);
		host.wr(SPACE_A, OFF_PEER_WAIT, 8'h5A);
		host.rd(SPACE_B, OFF_GUARD, d);
		chk(d, RST_GUARD);
		host.rd(SPACE_A, OFF_PEER_WAIT, d);
		chk(d, 8'h5A);
		host.wr(SPACE_A, 6'h3F, 8'hFF);
		host.rd(SPACE_A, 6'h3F, d);
		chk(d, 8'h00);
		host.rd(SPACE_B, OFF_CLR_MAIN, d);
		chk(d, 8'h00);
	endtask : t_space

	task automatic t_mask();
		logic [7:0] d;
		for (int g = 0; g < 4; g++)
		begin
			host.rd(SPACE_A, 6'(OFF_MASK_MAIN + g), d);
			chk(d, RST_MASK);
			host.wr(SPACE_A, 6'(OFF_MASK_MAIN + g), 8'hFF);
			host.rd(SPACE_A, 6'(OFF_MASK_MAIN + g), d);
			chk(d, vld[g]);
			host.wr(SPACE_A, 6'(OFF_MASK_MAIN + g), 8'h00);
		end
	endtask : t_mask

	// source event while masked, then unmask, write-clear and read-clear
	task automatic t_irq();
		logic [7:0] d;
		for (int g = 0; g < 4; g++)
		begin
			host.wr(SPACE_A, 6'(OFF_MASK_MAIN + g), 8'h80);
			@(posedge clk_in);
			events <= nfcreg_irq_t'(32'h80 << (8 * (3 - g)));
			@(posedge clk_in);
			events <= '0;
			#1;
			chk(8'(irq), 8'h00);
			host.wr(SPACE_A, 6'(OFF_MASK_MAIN + g), 8'h00);
			#1;
			chk(8'(irq), 8'h01);
			host.wr(SPACE_B, 6'(OFF_CLR_MAIN + g), 8'h80);
			#1;
			chk(8'(irq), 8'h00);
			@(posedge clk_in);
			events <= nfcreg_irq_t'(32'h80 << (8 * (3 - g)));
			@(posedge clk_in);
			events <= '0;
			host.rd(SPACE_A, 6'(OFF_STAT_MAIN + g), d);
			chk(d, 8'h80);
			chk(8'(irq), 8'h00);
			host.rd(SPACE_A, 6'(OFF_STAT_MAIN + g), d);
			chk(d, 8'h00);
		end
	endtask : t_irq

	task automatic t_peer();
		logic [7:0] d;
		int n;
		@(posedge clk_in);
		mode <= 1'b1;
		host.wr(SPACE_A, OFF_PEER_WAIT, 8'h02);
		pulse(2);
		wait_for(2, 400, n);
		rng(n, 2 * FC_STEP_PEER - 1, 2 * FC_STEP_PEER + 4);
		host.rd(SPACE_A, OFF_STAT_TGT, d);
		chk(d, 8'h01 << BIT_TGT_PEER_WAIT);
		@(posedge clk_in);
		mode <= 1'b0;
	endtask : t_peer

	// every mask set hides all flags; a status read and an event in one cycle keep the event
	task automatic t_hold();
		logic [7:0] d;
		for (int g = 0; g < 4; g++)
			host.wr(SPACE_A, 6'(OFF_MASK_MAIN + g), 8'hFF);
		@(posedge clk_in);
		events <= 32'hFFFFFFFF;
		@(posedge clk_in);
		events <= '0;
		#1;
		chk(8'(irq), 8'h00);
		host.wr(SPACE_A, OFF_MASK_MAIN, 8'h00);
		#1;
		chk(8'(irq), 8'h01);
		for (int g = 0; g < 4; g++)
		begin
			host.wr(SPACE_B, 6'(OFF_CLR_MAIN + g), 8'hFF);
			host.wr(SPACE_A, 6'(OFF_MASK_MAIN + g), 8'h00);
		end
		#1;
		chk(8'(irq), 8'h00);
		fork
			host.rd(SPACE_A, OFF_STAT_ERR, d);
			begin
				@(posedge clk_in);
				events <= 32'h00008000;
				@(posedge clk_in);
				events <= '0;
			end
		join
		chk(d, 8'h00);
		chk(8'(irq), 8'h01);
		host.rd(SPACE_A, OFF_STAT_ERR, d);
		chk(d, 8'h80);
		// a write taken while the clock enable is low must be lost
		@(posedge clk_in);
		ce_in <= 1'b0;
		host.wr(SPACE_A, OFF_PEER_WAIT, 8'h11);
		ce_in <= 1'b1;
		host.rd(SPACE_A, OFF_PEER_WAIT, d);
		chk(d, 8'h5A);
	endtask : t_hold

	task automatic t_squelch(input logic [7:0] s, input logic [7:0] m, input logic st,
		input int fall, input logic lock);
		int n1;
		int n2;
		host.wr(SPACE_B, OFF_SQUELCH, s);
		@(posedge clk_in);
		mrt <= m;
		step <= st;
		pulse(0);
		wait_for(0, 600, n1);
		rng(n1, SQ_DELAY_CYC, SQ_DELAY_CYC + 2);
		wait_for(1, 5000, n2);
		rng(n1 + n2, fall - 1, fall + 3);
		chk(8'(g_lock), 8'(lock));
	endtask : t_squelch

	task automatic t_guard(input logic [7:0] v);
		logic [7:0] d;
		int n;
		host.wr(SPACE_B, OFF_GUARD, v);
		pulse(1);
		@(posedge clk_in);
		#1;
		chk(8'(g_act), 8'h01);
		wait_for(3, 6000, n);
		rng(n + 1, GUARD_BASE_CYC + v * FC_STEP_GUARD, GUARD_BASE_CYC + v * FC_STEP_GUARD + 4);
		host.rd(SPACE_A, OFF_STAT_TMR, d);
		chk(d, 8'h01 << BIT_TMR_GUARD);
		chk(8'(g_act), 8'h00);
	endtask : t_guard

	// ==========================================================
	// main sequence
	initial
	begin
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		t_space();
		t_mask();
		t_irq();
		t_hold();
		t_peer();
		t_squelch(8'h0A, 8'h14, 1'b0, 10 * FC_STEP_MRT_FINE, 1'b1);
		t_squelch(8'h03, 8'h14, 1'b0, 20 * FC_STEP_MRT_FINE, 1'b0);
		t_squelch(8'h06, 8'h02, 1'b1, 2 * FC_STEP_MRT_COARSE, 1'b0);
		t_guard(8'h00);
		t_guard(8'h01);
		close_out();
	end
endmodule : nfcreg_top_tb
